// ===== core/aiode_events.v
// Limit monitors, diagnostic event handling and record readout of the four-channel input.
`include "aiode_regs.vh"
module aiode_events #(
  parameter CLK_HZ = `AIODE_CLK_HZ
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire param_wr_i,
  input wire [1:0] param_ch_i,
  input wire [7:0] param_speed_i,
  input wire param_mains60_i,
  input wire [15:0] param_high_i,
  input wire [15:0] param_low_i,
  input wire [15:0] param_nom_min_i,
  input wire [15:0] param_nom_max_i,
  input wire param_limit_en_i,
  input wire param_wire_break_en_i,
  input wire param_diag_en_i,
  input wire sample_valid_i,
  input wire [1:0] sample_ch_i,
  input wire [15:0] sample_value_i,
  input wire [3:0] wire_break_i,
  input wire [3:0] range_over_i,
  input wire [3:0] range_under_i,
  input wire comm_err_i,
  input wire canopen_attached_i,
  input wire proc_ack_i,
  input wire diag_ack_i,
  input wire rd_req_i,
  input wire rd_by_record_i,
  input wire [7:0] record_set_number_i,
  input wire [15:0] object_index_i,
  input wire [7:0] object_subindex_i,
  output reg rd_valid_o,
  output reg [7:0] rd_data_o,
  output reg rd_err_o,
  output reg proc_irq_emcy_o,
  output reg proc_irq_diagmsg_o,
  output reg diag_incoming_o,
  output reg diag_going_o,
  output reg [2:0] diag_source_o,
  output reg module_fault_indicator_o,
  output reg [47:0] conv_time_o
);
  // Conversion time in tenths of a millisecond for a speed code and mains frequency.
  function [11:0] conv_tenths;
    input [3:0] code;
    input m60;
    begin
      case (code)
        4'h0: conv_tenths = m60 ? 12'hA91 : 12'hCA9;
        4'h1: conv_tenths = m60 ? 12'h55C : 12'h66A;
        4'h2: conv_tenths = m60 ? 12'h2C1 : 12'h34A;
        4'h3: conv_tenths = m60 ? 12'h174 : 12'h1B9;
        4'h4: conv_tenths = m60 ? 12'h0CD : 12'h0F2;
        4'h5: conv_tenths = m60 ? 12'h07A : 12'h08E;
        4'h6: conv_tenths = m60 ? 12'h050 : 12'h05C;
        4'h7: conv_tenths = m60 ? 12'h03B : 12'h042;
        4'h8: conv_tenths = m60 ? 12'h026 : 12'h02A;
        default: conv_tenths = 12'h000;
      endcase
    end
  endfunction

  // True when a limit value lies inside the nominal range or is its own disable code.
  function limit_ok;
    input [15:0] lim;
    input [15:0] off_code;
    input [15:0] nmin;
    input [15:0] nmax;
    begin
      limit_ok = (lim == off_code) || (($signed(lim) >= $signed(nmin)) && ($signed(lim) <= $signed(nmax)));
    end
  endfunction

  // The block reset stands in for power-on, so the ticker restarts from zero with it.
  wire [31:0] us_count;
  aiode_us_ticker #(
    .CLK_HZ(CLK_HZ),
    .TICK_HZ(`AIODE_TICK_HZ)
  ) u_ticker (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .count_o(us_count)
  );

  reg [3:0] speed [0:3];
  reg [15:0] high_thr [0:3];
  reg [15:0] low_thr [0:3];
  reg [3:0] mains60;
  reg [3:0] limit_en;
  reg [3:0] wb_en;
  reg [3:0] param_err;
  reg diag_en;
  reg [3:0] above;
  reg [3:0] below;
  reg [7:0] limit_high_event_flags;
  reg [7:0] limit_low_event_flags;
  reg [15:0] event_timestamp_low;
  reg proc_pending;
  reg proc_lost;
  reg [4:0] diag_active;
  reg diag_pending;
  reg diag_bufovf;
  reg [7:0] chan_err [0:3];
  integer i;
  integer p;
  integer c;

  // Parameter writes are checked before they take effect; a bad set keeps the old limits.
  wire speed_ok = param_speed_i <= `AIODE_SPEED_MAX; // R1
  wire high_ok = limit_ok(param_high_i, `AIODE_HIGH_OFF, param_nom_min_i, param_nom_max_i); // R2
  wire low_ok = limit_ok(param_low_i, `AIODE_LOW_OFF, param_nom_min_i, param_nom_max_i); // R2
  wire param_good = speed_ok && high_ok && low_ok;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (p = 0; p < 4; p = p + 1) begin
        speed[p] <= 4'h0;
        high_thr[p] <= `AIODE_HIGH_OFF;
        low_thr[p] <= `AIODE_LOW_OFF;
      end
      mains60 <= 4'h0;
      limit_en <= 4'h0;
      wb_en <= 4'h0;
      param_err <= 4'h0;
      diag_en <= 1'b0;
    end else if (param_wr_i) begin
      diag_en <= param_diag_en_i;
      if (param_good) begin
        speed[param_ch_i] <= param_speed_i[3:0]; // R1
        mains60[param_ch_i] <= param_mains60_i;
        high_thr[param_ch_i] <= param_high_i;
        low_thr[param_ch_i] <= param_low_i;
        limit_en[param_ch_i] <= param_limit_en_i;
        wb_en[param_ch_i] <= param_wire_break_en_i; // R5
        param_err[param_ch_i] <= 1'b0;
      end else begin
        param_err[param_ch_i] <= 1'b1; // R2
      end
    end
  end

  // Limit monitors: signed compare, disabled by the extreme codes, edge-triggered.
  wire [15:0] s_high = high_thr[sample_ch_i];
  wire [15:0] s_low = low_thr[sample_ch_i];
  wire hi_on = limit_en[sample_ch_i] && (s_high != `AIODE_HIGH_OFF)
               && ($signed(sample_value_i) > $signed(s_high)); // R3 R4 R20
  wire lo_on = limit_en[sample_ch_i] && (s_low != `AIODE_LOW_OFF)
               && ($signed(sample_value_i) < $signed(s_low)); // R3 R4 R20
  reg [3:0] new_hi;
  reg [3:0] new_lo;
  always @* begin
    new_hi = 4'h0;
    new_lo = 4'h0;
    if (sample_valid_i) begin
      new_hi[sample_ch_i] = hi_on && !above[sample_ch_i]; // R21
      new_lo[sample_ch_i] = lo_on && !below[sample_ch_i]; // R21
    end
  end
  wire proc_event = |{new_hi, new_lo};
  // An acknowledge in the same cycle as a new event frees the record for it.
  wire proc_busy = proc_pending && !proc_ack_i;

  // Record read decode, also used for the read side effect on the lost and overflow flags.
  reg [7:0] next_rd_data;
  reg next_rd_err;
  reg errd_read;
  reg [7:0] diag_off;
  reg diag_sel;
  reg [7:0] diag_len;
  wire [7:0] err_a = {param_err != 4'h0, 3'b000, diag_active[3:0] != 4'h0, 2'b00, diag_active != 5'h00};
  reg [7:0] err_d;
  always @* begin
    err_d = 8'h00;
    err_d[`AIODE_ERRD_BUFOVF_BIT] = diag_bufovf; // R19
    err_d[`AIODE_ERRD_COMM_BIT] = comm_err_i;
    err_d[`AIODE_ERRD_LOST_BIT] = proc_lost; // R19
  end
  always @* begin
    next_rd_data = 8'h00;
    next_rd_err = 1'b0;
    errd_read = 1'b0;
    diag_sel = 1'b0;
    diag_off = 8'h00;
    diag_len = `AIODE_DIAG_LEN;
    if (rd_by_record_i) begin
      diag_off = object_subindex_i;
      if (record_set_number_i == `AIODE_RECSET_DIAG_FULL) begin
        diag_sel = 1'b1; // R16
      end else if (record_set_number_i == `AIODE_RECSET_DIAG_SHORT) begin
        diag_sel = 1'b1; // R16
        diag_len = `AIODE_DIAG_SHORT_LEN;
      end
    end else if (object_index_i == `AIODE_INDEX_DIAG_FULL || object_index_i == `AIODE_INDEX_DIAG_SHORT) begin
      diag_sel = object_subindex_i >= `AIODE_SUB_DIAG_BASE; // R17
      diag_off = object_subindex_i - `AIODE_SUB_DIAG_BASE;
      if (object_index_i == `AIODE_INDEX_DIAG_SHORT) begin
        diag_len = `AIODE_DIAG_SHORT_LEN; // R17
      end
    end
    if (diag_sel && diag_off < diag_len) begin
      case (diag_off[3:0])
        4'h0: next_rd_data = err_a;
        4'h1: next_rd_data = `AIODE_MODTYP_VAL;
        4'h3: begin
          next_rd_data = err_d;
          errd_read = rd_req_i;
        end
        4'h4: next_rd_data = `AIODE_CHTYP_VAL;
        4'h5: next_rd_data = `AIODE_NUMBIT_VAL;
        4'h6: next_rd_data = `AIODE_NUMCH_VAL;
        4'h7: next_rd_data = {4'h0, diag_active[3:0]};
        4'h8: next_rd_data = chan_err[0];
        4'h9: next_rd_data = chan_err[1];
        4'hA: next_rd_data = chan_err[2];
        4'hB: next_rd_data = chan_err[3];
        default: next_rd_data = 8'h00;
      endcase
    end else if (!rd_by_record_i && object_index_i == `AIODE_INDEX_PROC) begin
      case (object_subindex_i)
        `AIODE_SUB_HIGH_FLAGS: next_rd_data = limit_high_event_flags; // R8
        `AIODE_SUB_LOW_FLAGS: next_rd_data = limit_low_event_flags; // R8
        `AIODE_SUB_STAMP_LO: next_rd_data = event_timestamp_low[7:0]; // R8
        `AIODE_SUB_STAMP_HI: next_rd_data = event_timestamp_low[15:8]; // R8
        default: next_rd_err = 1'b1;
      endcase
    end else begin
      next_rd_err = 1'b1;
    end
  end

  // Diagnostic causes: one slot per channel plus a module-level slot.
  reg [4:0] cause;
  reg [2:0] pick;
  reg pick_hit;
  always @* begin
    for (c = 0; c < 4; c = c + 1) begin
      cause[c] = param_err[c] || (wire_break_i[c] && wb_en[c]) || range_over_i[c] || range_under_i[c]; // R5
    end
    cause[4] = comm_err_i || proc_lost || diag_bufovf; // R5
    pick = 3'h0;
    pick_hit = 1'b0;
    // Lowest slot wins; a cause that flips back while it waits is never reported.
    for (c = 4; c >= 0; c = c - 1) begin
      if (cause[c] != diag_active[c]) begin
        pick = c[2:0];
        pick_hit = 1'b1;
      end
    end
  end
  wire diag_fire = diag_en && pick_hit;
  wire diag_busy = diag_pending && !diag_ack_i;
  reg [4:0] next_active;
  always @* begin
    next_active = diag_active;
    if (!diag_en) begin
      next_active = 5'h00;
    end else if (pick_hit) begin
      next_active[pick] = cause[pick]; // R12 R13
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      above <= 4'h0;
      below <= 4'h0;
      limit_high_event_flags <= 8'h00;
      limit_low_event_flags <= 8'h00;
      event_timestamp_low <= 16'h0000;
      proc_pending <= 1'b0;
      proc_lost <= 1'b0;
      proc_irq_emcy_o <= 1'b0;
      proc_irq_diagmsg_o <= 1'b0;
      diag_active <= 5'h00;
      diag_pending <= 1'b0;
      diag_bufovf <= 1'b0;
      diag_incoming_o <= 1'b0;
      diag_going_o <= 1'b0;
      diag_source_o <= 3'h0;
      module_fault_indicator_o <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        chan_err[i] <= 8'h00;
      end
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      rd_err_o <= 1'b0;
      conv_time_o <= 48'h000000000000;
    end else begin
      if (sample_valid_i) begin
        above[sample_ch_i] <= hi_on;
        below[sample_ch_i] <= lo_on;
      end
      proc_irq_emcy_o <= 1'b0;
      proc_irq_diagmsg_o <= 1'b0;
      if (proc_event && !proc_busy) begin
        limit_high_event_flags <= {4'h0, new_hi}; // R6
        limit_low_event_flags <= {4'h0, new_lo}; // R7
        event_timestamp_low <= us_count[15:0]; // R11
        proc_pending <= 1'b1;
        proc_irq_emcy_o <= canopen_attached_i; // R18
        proc_irq_diagmsg_o <= !canopen_attached_i; // R18
      end else if (proc_ack_i) begin
        proc_pending <= 1'b0;
      end
      // Set wins over the clear-on-read of the diagnostic byte.
      if (proc_event && proc_busy) begin
        proc_lost <= 1'b1; // R19
      end else if (errd_read) begin
        proc_lost <= 1'b0;
      end
      if (diag_fire && diag_busy) begin
        diag_bufovf <= 1'b1; // R19
      end else if (errd_read) begin
        diag_bufovf <= 1'b0;
      end
      if (diag_fire) begin
        diag_pending <= 1'b1;
      end else if (diag_ack_i) begin
        diag_pending <= 1'b0;
      end
      diag_active <= next_active;
      diag_incoming_o <= diag_fire && cause[pick]; // R12
      diag_going_o <= diag_fire && !cause[pick]; // R13
      if (diag_fire) begin
        diag_source_o <= pick;
      end
      // Channel detail is frozen while its slot is active, so later events are dropped.
      for (i = 0; i < 4; i = i + 1) begin
        if (!diag_active[i]) begin
          chan_err[i] <= {4'h0, range_under_i[i], range_over_i[i], wire_break_i[i] && wb_en[i], param_err[i]}; // R14
        end
      end
      module_fault_indicator_o <= next_active != 5'h00; // R15
      rd_valid_o <= rd_req_i;
      rd_data_o <= rd_req_i ? next_rd_data : 8'h00;
      rd_err_o <= rd_req_i && next_rd_err;
      for (i = 0; i < 4; i = i + 1) begin
        conv_time_o[i*12 +: 12] <= conv_tenths(speed[i], mains60[i]); // R1
      end
    end
  end
endmodule

// ===== core/aiode_regs.vh
// Constants for the analog input limit and diagnostic event block.
// What this block does
// (R1) Each channel holds a conversion-speed code 00h..08h selecting a conversion time.
// (R2) Limits are accepted only inside the nominal range or as their disable code, otherwise a parameterization error.
// (R3) Upper limit 7FFFh or lower limit 8000h switches that limit monitor off.
// (R4) A value beyond an active, enabled limit raises a process interrupt.
// (R5) Listed faults go out as diagnostic interrupts; only wire break has an enable.
// (R6) Process record overflow byte: bit n flags channel n, bits 7..4 read zero.
// (R7) Process record underflow byte: bit n flags channel n, bits 7..4 read zero.
// (R8) Index 5000h: overflow at subindex 02h, underflow 03h, timestamp 04h and 05h.
// (R9) A 32-bit microsecond counter starts from zero at power-on.
// (R10) The microsecond counter wraps to zero after its maximum and keeps counting.
// (R11) The low 16 counter bits are captured at each process interrupt into the timestamp field.
// (R12) With diagnostic interrupts enabled, a new fault issues an incoming interrupt with data.
// (R13) When the fault cause vanishes a going interrupt follows by itself.
// (R14) Further events of a channel between incoming and going are dropped.
// (R15) The module fault indicator is lit from first incoming to last going interrupt.
// (R16) Record set 01h serves the diagnostic record, record set 00h its first four bytes.
// (R17) Object index 2F01h serves the diagnostic record, 2F00h its first four bytes.
// (R18) Process interrupts go as emergency message on CANopen, else as diagnostic message.
// (R19) Diagnostic byte bit 6 flags a lost process interrupt, bit 3 a buffer overflow.
// (R20) Limits and values compare as signed 16-bit two's complement numbers.
// (R21) A limit event fires only on entry into the out-of-limit state.
`ifndef AIODE_REGS_VH
`define AIODE_REGS_VH
`define AIODE_SPEED_MAX 8'h08
`define AIODE_HIGH_OFF 16'h7FFF
`define AIODE_LOW_OFF 16'h8000
`define AIODE_INDEX_PROC 16'h5000
`define AIODE_INDEX_DIAG_FULL 16'h2F01
`define AIODE_INDEX_DIAG_SHORT 16'h2F00
`define AIODE_RECSET_DIAG_FULL 8'h01
`define AIODE_RECSET_DIAG_SHORT 8'h00
`define AIODE_SUB_HIGH_FLAGS 8'h02
`define AIODE_SUB_LOW_FLAGS 8'h03
`define AIODE_SUB_STAMP_LO 8'h04
`define AIODE_SUB_STAMP_HI 8'h05
`define AIODE_SUB_DIAG_BASE 8'h02
`define AIODE_DIAG_SHORT_LEN 8'h04
`define AIODE_DIAG_LEN 8'h10
`define AIODE_MODTYP_VAL 8'h15
`define AIODE_CHTYP_VAL 8'h71
`define AIODE_NUMBIT_VAL 8'h08
`define AIODE_NUMCH_VAL 8'h04
`define AIODE_ERRD_BUFOVF_BIT 3
`define AIODE_ERRD_COMM_BIT 4
`define AIODE_ERRD_LOST_BIT 6
`define AIODE_ERRA_FAIL_BIT 0
`define AIODE_ERRA_CHAN_BIT 3
`define AIODE_ERRA_PARAM_BIT 7
`define AIODE_CLK_HZ 50000000
`define AIODE_TICK_HZ 1000000
`endif

// ===== core/aiode_us_ticker.v
// Free-running 32-bit microsecond counter derived from the module clock.
`include "aiode_regs.vh"
module aiode_us_ticker #(
  parameter CLK_HZ = `AIODE_CLK_HZ,
  parameter TICK_HZ = `AIODE_TICK_HZ
) (
  input wire clk_i,
  input wire rst_n_i,
  output reg [31:0] count_o
);
  // The prescaler is eight bits wide, so CLK_HZ may be at most 256 times TICK_HZ.
  localparam [31:0] DIV_COUNT = CLK_HZ / TICK_HZ - 1;
  localparam [7:0] DIV_LAST = DIV_COUNT[7:0];
  reg [7:0] prescale;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescale <= 8'h00;
      count_o <= 32'h00000000; // R9
    end else if (prescale == DIV_LAST) begin
      prescale <= 8'h00;
      // The natural 32-bit carry-out drop gives the wrap to zero.
      count_o <= count_o + 32'h00000001; // R10
    end else begin
      prescale <= prescale + 8'h01;
    end
  end
endmodule

// ===== dv/aiode_monitor.sv
// Concurrent checks on the read, process interrupt and fault ports of the event block.
module aiode_monitor (
  input wire clk_i,
  input wire rst_n_i,
  input wire rd_req_i,
  input wire rd_by_record_i,
  input wire [7:0] record_set_number_i,
  input wire [7:0] object_subindex_i,
  input wire sample_valid_i,
  input wire canopen_attached_i,
  input wire rd_valid_o,
  input wire rd_err_o,
  input wire proc_irq_emcy_o,
  input wire proc_irq_diagmsg_o,
  input wire diag_incoming_o,
  input wire diag_going_o,
  input wire module_fault_indicator_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (rd_req_i |=> rd_valid_o)
    else $error("read request not answered next cycle");
  a_read_cause: assert property (rd_valid_o |-> $past(rd_req_i))
    else $error("read answer without request");
  a_short_set: assert property (rd_req_i && rd_by_record_i && record_set_number_i == 8'h00 &&
    object_subindex_i > 8'h03 |=> rd_err_o) else $error("short record read past four bytes");
  a_full_set: assert property (rd_req_i && rd_by_record_i && record_set_number_i == 8'h01 &&
    object_subindex_i < 8'h10 |=> !rd_err_o) else $error("full record read refused");
  a_emcy_route: assert property (proc_irq_emcy_o |-> $past(canopen_attached_i) && $past(sample_valid_i))
    else $error("emergency message without fieldbus or sample");
  a_msg_route: assert property (proc_irq_diagmsg_o |-> !$past(canopen_attached_i) && $past(sample_valid_i))
    else $error("diagnostic message route wrong");
  a_fault_rise: assert property ($rose(module_fault_indicator_o) |-> diag_incoming_o)
    else $error("fault indicator lit without incoming interrupt");
  a_fault_fall: assert property ($fell(module_fault_indicator_o) |-> diag_going_o)
    else $error("fault indicator dark without going interrupt");
endmodule

// ===== dv/aiode_host_model.sv
// Host model on the backplane: reads records and acknowledges interrupts at once.
module aiode_host_model (
  input wire clk_i,
  input wire proc_irq_i,
  input wire diag_irq_i,
  input wire rd_valid_i,
  input wire [7:0] rd_data_i,
  input wire rd_err_i,
  output logic rd_req_o,
  output logic rd_by_record_o,
  output logic [7:0] rec_o,
  output logic [15:0] idx_o,
  output logic [7:0] sub_o,
  output logic proc_ack_o,
  output logic diag_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {rd_req_o, rd_by_record_o, rec_o, idx_o, sub_o, proc_ack_o, diag_ack_o} = '0;
  end
  // Acknowledging in the pulse cycle keeps the pending queues empty.
  always @(posedge clk_i) begin
    #1;
    proc_ack_o = proc_irq_i;
    diag_ack_o = diag_irq_i;
  end
  // The answer is fixed one cycle after the request edge; v is {valid, err, data}.
  task automatic read(input logic b, input logic [7:0] r, input logic [15:0] x, input logic [7:0] s,
    output logic [9:0] v);
    @(posedge clk_i);
    #1;
    {rd_req_o, rd_by_record_o, rec_o, idx_o, sub_o} = {1'b1, b, r, x, s};
    @(posedge clk_i);
    #1;
    v = {rd_valid_i, rd_err_i, rd_data_i};
    // Released address lines show the inverse so stale values cannot pass.
    {rd_req_o, rec_o, idx_o, sub_o} = {1'b0, ~r, ~x, ~s};
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the limit and diagnostic event block.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_n_i = 1'b0, param_wr_i = 1'b0, param_mains60_i = 1'b0, param_limit_en_i = 1'b0;
  logic param_wire_break_en_i = 1'b0, param_diag_en_i = 1'b0, sample_valid_i = 1'b0, comm_err_i = 1'b0;
  logic canopen_attached_i = 1'b1, proc_ack_i, diag_ack_i, rd_req_i, rd_by_record_i;
  logic [1:0] param_ch_i = 2'h0, sample_ch_i = 2'h0;
  logic [3:0] wire_break_i = 4'h0, range_over_i = 4'h0, range_under_i = 4'h0;
  logic [7:0] param_speed_i = 8'h00, record_set_number_i, object_subindex_i, rd_data_o;
  logic [15:0] param_high_i = 16'h7FFF, param_low_i = 16'h8000, sample_value_i = 16'h0000, object_index_i;
  logic [15:0] param_nom_min_i = 16'hF830, param_nom_max_i = 16'h07D0;
  logic rd_valid_o, rd_err_o, proc_irq_emcy_o, proc_irq_diagmsg_o, diag_incoming_o, diag_going_o;
  logic module_fault_indicator_o;
  logic [2:0] diag_source_o;
  logic [47:0] conv_time_o;
  logic [9:0] v;
  logic [15:0] st_a;
  int n_errors = 0, n_checks = 0, cyc = 0, t_a;
  aiode_events uut (.*);
  aiode_host_model host (.clk_i(clk_i), .proc_irq_i(proc_irq_emcy_o | proc_irq_diagmsg_o),
    .diag_irq_i(diag_incoming_o | diag_going_o), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .rd_err_i(rd_err_o), .rd_req_o(rd_req_i), .rd_by_record_o(rd_by_record_i), .rec_o(record_set_number_i),
    .idx_o(object_index_i), .sub_o(object_subindex_i), .proc_ack_o(proc_ack_i), .diag_ack_o(diag_ack_i));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pwr(input logic [1:0] ch, input logic [7:0] sp, input logic m6, input logic [15:0] hi, lo,
    input logic en);
    step();
    {param_wr_i, param_ch_i, param_speed_i, param_mains60_i} = {1'b1, ch, sp, m6};
    {param_high_i, param_low_i, param_limit_en_i} = {hi, lo, en};
    step();
    param_wr_i = 1'b0;
  endtask
  // Judges the two interrupt routes in the cycle after the sample edge.
  task automatic smp(input logic [1:0] ch, input logic [15:0] val, input logic [1:0] exp);
    step();
    t_a = cyc;
    {sample_valid_i, sample_ch_i, sample_value_i} = {1'b1, ch, val};
    step();
    sample_valid_i = 1'b0;
    check({proc_irq_emcy_o, proc_irq_diagmsg_o}, exp);
  endtask
  task automatic t_reads();
    for (int s = 2; s < 6; s++) begin
      host.read(1'b0, 8'h00, 16'h5000, s[7:0], v);
      check(v, 10'h200);
    end
    host.read(1'b1, 8'h01, 16'h0000, 8'h01, v);
    check(v, 10'h215);
    host.read(1'b1, 8'h01, 16'h0000, 8'h0F, v);
    check(v, 10'h200);
    host.read(1'b1, 8'h00, 16'h0000, 8'h04, v);
    check(v, 10'h300);
    host.read(1'b0, 8'h00, 16'h2F01, 8'h06, v);
    check(v, 10'h271);
    host.read(1'b0, 8'h00, 16'h2F00, 8'h06, v);
    check(v, 10'h300);
    host.read(1'b0, 8'h00, 16'h1234, 8'h02, v);
    check(v, 10'h300);
  endtask
  task automatic t_speed();
    logic [11:0] tbl [0:17];
    tbl = '{12'hCA9, 12'h66A, 12'h34A, 12'h1B9, 12'h0F2, 12'h08E, 12'h05C, 12'h042, 12'h02A,
      12'hA91, 12'h55C, 12'h2C1, 12'h174, 12'h0CD, 12'h07A, 12'h050, 12'h03B, 12'h026};
    for (int i = 0; i < 18; i++) begin
      pwr(2'h0, 8'(i % 9), i > 8, 16'h7FFF, 16'h8000, 1'b0);
      step();
      check(conv_time_o[11:0], tbl[i]);
    end
    pwr(2'h0, 8'h09, 1'b0, 16'h7FFF, 16'h8000, 1'b0);
    step();
    check(conv_time_o[11:0], 12'h026);
    check(conv_time_o[23:12], 12'hCA9);
  endtask
  task automatic t_limits();
    pwr(2'h0, 8'h00, 1'b0, 16'h03E8, 16'hFC18, 1'b1);
    smp(2'h0, 16'h03E9, 2'b10);
    st_a = 16'(t_a);
    host.read(1'b0, 8'h00, 16'h5000, 8'h02, v);
    check(v, 10'h201);
    smp(2'h0, 16'h03E9, 2'b00);
    smp(2'h0, 16'h03E8, 2'b00);
    host.read(1'b0, 8'h00, 16'h5000, 8'h04, v);
    st_a = {8'h00, v[7:0]};
    host.read(1'b0, 8'h00, 16'h5000, 8'h05, v);
    st_a[15:8] = v[7:0];
    // Ten microseconds later the captured stamp must be ten counts higher.
    while (cyc < t_a + 499) step();
    canopen_attached_i = 1'b0;
    smp(2'h0, 16'hFC17, 2'b01);
    host.read(1'b0, 8'h00, 16'h5000, 8'h03, v);
    check(v, 10'h201);
    host.read(1'b0, 8'h00, 16'h5000, 8'h02, v);
    check(v, 10'h200);
    host.read(1'b0, 8'h00, 16'h5000, 8'h04, v);
    t_a = v[7:0];
    host.read(1'b0, 8'h00, 16'h5000, 8'h05, v);
    check(16'({v[7:0], 8'(t_a)} - st_a), 16'h000A);
    pwr(2'h2, 8'h00, 1'b0, 16'h0064, 16'h8000, 1'b1);
    smp(2'h2, 16'hFF00, 2'b00);
    smp(2'h2, 16'h0065, 2'b01);
    pwr(2'h1, 8'h00, 1'b0, 16'h7FFF, 16'h8000, 1'b1);
    smp(2'h1, 16'h7FFF, 2'b00);
    smp(2'h1, 16'h8000, 2'b00);
    host.read(1'b1, 8'h01, 16'h0000, 8'h00, v);
    check(v, 10'h200);
    pwr(2'h3, 8'h00, 1'b0, 16'h0064, 16'hFF9C, 1'b0);
    smp(2'h3, 16'h0100, 2'b00);
    pwr(2'h0, 8'h00, 1'b0, 16'h0BB8, 16'hFC18, 1'b1);
    smp(2'h0, 16'h05DC, 2'b01);
    pwr(2'h0, 8'h00, 1'b0, 16'h7FFF, 16'h8000, 1'b0);
  endtask
  task automatic t_diag();
    {param_diag_en_i, param_wire_break_en_i} = 2'b11;
    pwr(2'h1, 8'h00, 1'b0, 16'h7FFF, 16'h8000, 1'b0);
    step();
    wire_break_i[1] = 1'b1;
    step();
    check({diag_incoming_o, diag_going_o, diag_source_o, module_fault_indicator_o}, 6'h23);
    check({proc_irq_emcy_o, proc_irq_diagmsg_o}, 2'b00);
    host.read(1'b1, 8'h01, 16'h0000, 8'h00, v);
    check(v, 10'h209);
    range_over_i[1] = 1'b1;
    step(2);
    check({diag_incoming_o, diag_going_o, module_fault_indicator_o}, 3'b001);
    host.read(1'b1, 8'h01, 16'h0000, 8'h09, v);
    check(v, 10'h202);
    {wire_break_i[1], range_over_i[1]} = 2'b00;
    step();
    check({diag_incoming_o, diag_going_o, diag_source_o, module_fault_indicator_o}, 6'h12);
    param_wire_break_en_i = 1'b0;
    pwr(2'h2, 8'h00, 1'b0, 16'h7FFF, 16'h8000, 1'b0);
    wire_break_i[2] = 1'b1;
    step(2);
    check({diag_incoming_o, module_fault_indicator_o}, 2'b00);
  endtask
  task automatic results();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    results();
  end
  initial begin
    step(10);
    rst_n_i = 1'b1;
    t_reads();
    t_speed();
    t_limits();
    t_diag();
    results();
  end
endmodule
bind aiode_events aiode_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
  .rd_by_record_i(rd_by_record_i), .record_set_number_i(record_set_number_i),
  .object_subindex_i(object_subindex_i), .sample_valid_i(sample_valid_i),
  .canopen_attached_i(canopen_attached_i), .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o),
  .proc_irq_emcy_o(proc_irq_emcy_o), .proc_irq_diagmsg_o(proc_irq_diagmsg_o), .diag_incoming_o(diag_incoming_o),
  .diag_going_o(diag_going_o), .module_fault_indicator_o(module_fault_indicator_o));
